//--- core/mda_defs.vh
// Constants for the motor drive action parameter block.
// Assumes a 32-bit classic Wishbone slave and a 250 MHz clock.
`ifndef MDA_DEFS_VH
`define MDA_DEFS_VH

// Register byte offsets
`define MDA_REG_MODE 8'h00
`define MDA_REG_CFG_CMD 8'h04
`define MDA_REG_SPD_GAIN 8'h08
`define MDA_REG_SPD_OFS 8'h0c
`define MDA_REG_TRQ_GAIN 8'h10
`define MDA_REG_TRQ_OFS 8'h14
`define MDA_REG_SPD_UPPER 8'h18
`define MDA_REG_VA_WIDTH 8'h1c
`define MDA_REG_HOLD_TRQ 8'h20
`define MDA_REG_STATUS 8'h24
`define MDA_REG_SPD_CMD 8'h28
`define MDA_REG_TRQ_CMD 8'h2c

// Mode register fields
`define MDA_F_WIRE 0
`define MDA_F_POL 1
`define MDA_F_HOLD 2
`define MDA_F_DECEL 5:4
`define MDA_F_FILT 9:8

// Reset values
`define MDA_RST_WIRE 1'b1
`define MDA_RST_POL 1'b1
`define MDA_RST_HOLD 1'b0
`define MDA_RST_DECEL 2'h0
`define MDA_RST_FILT 2'h0
`define MDA_RST_SPD_GAIN 12'd640
`define MDA_RST_SPD_OFS 12'sd0
`define MDA_RST_TRQ_GAIN 8'd43
`define MDA_RST_TRQ_OFS 8'sd0
`define MDA_RST_SPD_UPPER 12'd3150
`define MDA_RST_VA_WIDTH 9'd200
`define MDA_RST_HOLD_TRQ 7'sh7f

// Ranges and limits
`define MDA_SPD_GAIN_MAX 12'd3150
`define MDA_TRQ_GAIN_MAX 8'd200
`define MDA_VA_MIN 9'd1
`define MDA_VA_MAX 9'd400
`define MDA_TRQ_MAX 9'd200
`define MDA_HOLD_MAX 8'd50
`define MDA_HOLD_ANGLE_DEG 8'd15
`define MDA_MV_PER_V 32'd1000
`define MDA_FILT_NONE 2'd0
`define MDA_FILT_ONE 2'd1
`define MDA_FILT_TWO 2'd2
`define MDA_FILT1_SHIFT 3
`define MDA_FILT2_SHIFT 6

// Ramp tick period
`define MDA_CLK_MHZ 250
`define MDA_TICK_US 4
`define MDA_TICK_CYC (`MDA_TICK_US * `MDA_CLK_MHZ)

`endif

//--- core/mda_ramp.v
// Speed ramp generator with optional smoothing stage.
// Assumes target and step come from logic on the same clock.
`default_nettype none
`include "mda_defs.vh"

module mda_ramp #(
  parameter W = 12,
  parameter TICK = `MDA_TICK_CYC
) (
  input wire clk_i, // Clock
  input wire rst_i, // Synchronous reset
  input wire [W-1:0] target_i, // Wanted speed
  input wire [W-1:0] step_i, // Change per tick
  input wire [1:0] filt_i, // Smoothing select
  output reg [W-1:0] speed_o // Smoothed speed
);

////////////////////////////////////////////////////////////////////////
reg [15:0] tick_r;
reg [W-1:0] lin_r;
reg [W+7:0] acc_r;
wire tick = (tick_r == TICK[15:0] - 16'd1);
wire [W+7:0] lin_x = {lin_r, 8'h00};
wire [W+7:0] diff = lin_x - acc_r;
wire up = lin_x > acc_r;
reg [W+7:0] d_abs;

always @* begin
  d_abs = up ? diff : (acc_r - lin_x);
  case (filt_i)
    `MDA_FILT_ONE: d_abs = d_abs >> `MDA_FILT1_SHIFT;
    `MDA_FILT_TWO: d_abs = d_abs >> `MDA_FILT2_SHIFT;
    default: d_abs = d_abs;
  endcase
end

always @(posedge clk_i) begin
  if (rst_i) begin
    tick_r <= 16'h0000;
    lin_r <= {W{1'b0}};
    acc_r <= {(W+8){1'b0}};
    speed_o <= {W{1'b0}};
  end else begin
    tick_r <= tick ? 16'h0000 : tick_r + 16'd1;
    if (tick) begin
      if (target_i > lin_r)
        lin_r <= (target_i - lin_r > step_i) ? lin_r + step_i : target_i;
      else
        lin_r <= (lin_r - target_i > step_i) ? lin_r - step_i : target_i;
      // Lag stage stretches each ramp, so the real ramp time grows
      if (filt_i == `MDA_FILT_NONE)
        acc_r <= lin_x;
      else if (d_abs == {(W+8){1'b0}})
        acc_r <= lin_x;
      else
        acc_r <= up ? acc_r + d_abs : acc_r - d_abs;
    end
    speed_o <= acc_r[W+7:8];
  end
end

endmodule
`default_nettype wire

//--- core/mda_top.v
// Run control and parameter handling for the motor drive.
// Assumes run pins are asynchronous; analog samples, actual speed,
// shaft displacement and operation-data torque come from same-clock logic.
`default_nettype none
`include "mda_defs.vh"

module mda_top #(
  parameter SW = 12,
  parameter RAMP_STEP = 12'd1
) (
  input wire clk_i, // Clock, 250 MHz
  input wire rst_i, // Synchronous reset, active high
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire forward_run_input_i, // 2-wire forward run pin
  input wire reverse_run_i, // 2-wire reverse run pin
  input wire start_run_i, // 3-wire start pin
  input wire run_direction_input_i, // 3-wire direction pin
  input wire power_ok_i, // Driver power present pin
  input wire alarm_i, // Alarm condition pin
  input wire [13:0] spd_mv_i, // Analog speed input, mV
  input wire [13:0] trq_mv_i, // Analog torque input, mV
  input wire [SW-1:0] actual_speed_i, // Measured speed, r/min
  input wire signed [8:0] shaft_disp_i, // Shaft displacement, degrees
  input wire [7:0] opdata_trq_i, // Selected operation-data torque limit, %
  output reg run_o, // Motor running
  output reg cw_o, // 1 turns clockwise
  output reg [SW-1:0] speed_ref_o, // Ramped speed reference
  output reg [8:0] trq_limit_o, // Torque limit, %
  output reg [1:0] decel_mode_o, // Stop style code
  output reg hold_o, // Holding force active
  output reg [7:0] hold_trq_o, // Holding torque limit, %
  output reg speed_reached_output_o // Speed-reached output
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg [4:0] pin_s1_r;
reg [4:0] pin_s2_r;

always @(posedge clk_i) begin
  if (rst_i) begin
    pin_s1_r <= 5'h00;
    pin_s2_r <= 5'h00;
  end else begin
    pin_s1_r <= {alarm_i, power_ok_i, run_direction_input_i,
                 start_run_i, forward_run_input_i};
    pin_s2_r <= pin_s1_r;
  end
end

wire fwd_s = pin_s2_r[0];
wire start_s = pin_s2_r[1];
wire dir_s = pin_s2_r[2];
wire pwr_s = pin_s2_r[3];
wire alarm_s = pin_s2_r[4];

reg rev_s1_r;
reg rev_s2_r;

always @(posedge clk_i) begin
  if (rst_i) begin
    rev_s1_r <= 1'b0;
    rev_s2_r <= 1'b0;
  end else begin
    rev_s1_r <= reverse_run_i;
    rev_s2_r <= rev_s1_r;
  end
end

////////////////////////////////////////////////////////////////////////
// Parameter registers
reg wire_stg_r;
reg pol_stg_r;
reg hold_stg_r;
reg wire_r;
reg pol_r;
reg hold_en_r;
reg [1:0] decel_r;
reg [1:0] filt_stg_r;
reg [1:0] filt_r;
reg [11:0] spd_gain_r;
reg signed [11:0] spd_ofs_r;
reg [7:0] trq_gain_r;
reg signed [7:0] trq_ofs_r;
reg [11:0] spd_upper_r;
reg [8:0] va_width_r;
reg signed [6:0] hold_trq_r;
reg cfg_seen_r;

wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr = acc & wb_we_i;
wire [31:0] d = wb_dat_i;
wire lo = wb_sel_i[0];
wire lo2 = wb_sel_i[0] & wb_sel_i[1];
wire stopped = ~run_o & (speed_ref_o == {SW{1'b0}});

always @(posedge clk_i) begin
  if (rst_i) begin
    wire_stg_r <= `MDA_RST_WIRE;
    pol_stg_r <= `MDA_RST_POL;
    hold_stg_r <= `MDA_RST_HOLD;
    wire_r <= `MDA_RST_WIRE;
    pol_r <= `MDA_RST_POL;
    hold_en_r <= `MDA_RST_HOLD;
    decel_r <= `MDA_RST_DECEL;
    filt_stg_r <= `MDA_RST_FILT;
    filt_r <= `MDA_RST_FILT;
    spd_gain_r <= `MDA_RST_SPD_GAIN;
    spd_ofs_r <= `MDA_RST_SPD_OFS;
    trq_gain_r <= `MDA_RST_TRQ_GAIN;
    trq_ofs_r <= `MDA_RST_TRQ_OFS;
    spd_upper_r <= `MDA_RST_SPD_UPPER;
    va_width_r <= `MDA_RST_VA_WIDTH;
    hold_trq_r <= `MDA_RST_HOLD_TRQ;
    cfg_seen_r <= 1'b0;
  end else begin
    cfg_seen_r <= 1'b0;
    if (wr) begin
      case (wb_adr_i)
        `MDA_REG_MODE: begin
          if (lo) begin
            wire_stg_r <= d[`MDA_F_WIRE];
            pol_stg_r <= d[`MDA_F_POL];
            hold_stg_r <= d[`MDA_F_HOLD];
            if (d[`MDA_F_DECEL] <= 2'd2)
              decel_r <= d[`MDA_F_DECEL];
          end
          if (wb_sel_i[1] && d[`MDA_F_FILT] <= `MDA_FILT_TWO)
            filt_stg_r <= d[`MDA_F_FILT];
        end
        `MDA_REG_CFG_CMD:
          if (lo && d[0])
            cfg_seen_r <= 1'b1;
        `MDA_REG_SPD_GAIN:
          if (lo2 && d[11:0] <= `MDA_SPD_GAIN_MAX)
            spd_gain_r <= d[11:0];
        `MDA_REG_SPD_OFS:
          if (lo2)
            spd_ofs_r <= d[11:0];
        `MDA_REG_TRQ_GAIN:
          if (lo && d[7:0] <= `MDA_TRQ_GAIN_MAX)
            trq_gain_r <= d[7:0];
        `MDA_REG_TRQ_OFS:
          if (lo)
            trq_ofs_r <= d[7:0];
        `MDA_REG_SPD_UPPER:
          if (lo2)
            spd_upper_r <= d[11:0];
        `MDA_REG_VA_WIDTH:
          if (lo2 && d[8:0] >= `MDA_VA_MIN && d[8:0] <= `MDA_VA_MAX)
            va_width_r <= d[8:0];
        `MDA_REG_HOLD_TRQ:
          if (lo && $signed(d[7:0]) >= -8'sd1 && $signed(d[7:0]) <= 8'sd50)
            hold_trq_r <= d[6:0];
        default: ;
      endcase
    end
    // Configuration command moves class C settings into use
    if (cfg_seen_r) begin
      wire_r <= wire_stg_r;
      pol_r <= pol_stg_r;
      hold_en_r <= hold_stg_r;
    end
    // Filter choice only changes at standstill
    if (stopped)
      filt_r <= filt_stg_r;
  end
end

////////////////////////////////////////////////////////////////////////
// Analog scaling; products are in mV so divide back to volts
wire [31:0] spd_prod = {20'h0_0000, spd_gain_r} * {18'h0_0000, spd_mv_i};
wire [31:0] trq_prod = {24'h00_0000, trq_gain_r} * {18'h0_0000, trq_mv_i};
wire [31:0] spd_div = spd_prod / `MDA_MV_PER_V;
wire [31:0] trq_div = trq_prod / `MDA_MV_PER_V;
wire signed [17:0] spd_sum = $signed({2'b00, spd_div[15:0]}) +
                             {{6{spd_ofs_r[11]}}, spd_ofs_r};
wire signed [17:0] trq_sum = $signed({2'b00, trq_div[15:0]}) +
                             {{10{trq_ofs_r[7]}}, trq_ofs_r};
reg [11:0] spd_cmd_r;
reg [8:0] trq_cmd_r;

always @(posedge clk_i) begin
  if (rst_i) begin
    spd_cmd_r <= 12'h000;
    trq_cmd_r <= 9'h000;
  end else begin
    if (spd_sum < 18'sd0)
      spd_cmd_r <= 12'h000;
    else if (spd_sum > $signed({6'h00, spd_upper_r}))
      spd_cmd_r <= spd_upper_r;
    else
      spd_cmd_r <= spd_sum[11:0];
    if (trq_sum < 18'sd0)
      trq_cmd_r <= 9'h000;
    else if (trq_sum > $signed({9'h000, `MDA_TRQ_MAX}))
      trq_cmd_r <= `MDA_TRQ_MAX;
    else
      trq_cmd_r <= trq_sum[8:0];
  end
end

////////////////////////////////////////////////////////////////////////
// Run decode; positive sense is CW when polarity is 1
reg run_nxt;
reg plus_nxt;

always @* begin
  run_nxt = 1'b0;
  plus_nxt = 1'b1;
  if (wire_r) begin
    run_nxt = start_s;
    plus_nxt = dir_s;
  end else begin
    run_nxt = fwd_s ^ rev_s2_r; // Both on means stop
    plus_nxt = fwd_s;
  end
end

wire [SW-1:0] target = run_o ? spd_cmd_r[SW-1:0] : {SW{1'b0}};
wire [SW-1:0] ramp_spd;

mda_ramp #(
  .W(SW)
) u_ramp (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .target_i(target),
  .step_i(RAMP_STEP),
  .filt_i(filt_r),
  .speed_o(ramp_spd)
);

////////////////////////////////////////////////////////////////////////
// Speed window and load holding
// Window is taken around the set speed, not the ramp, so an unfinished ramp reads reached once measured speed is within the width
wire [SW-1:0] spd_err = (actual_speed_i > target) ?
                        actual_speed_i - target :
                        target - actual_speed_i;
wire [8:0] disp_abs = shaft_disp_i[8] ? (~shaft_disp_i + 9'd1) : shaft_disp_i;
wire [7:0] op_clip = (opdata_trq_i > `MDA_HOLD_MAX) ? `MDA_HOLD_MAX : opdata_trq_i;
// Holding limit never above 50 percent even when following operation data
wire [7:0] hold_lim = hold_trq_r[6] ? op_clip : {1'b0, hold_trq_r};
wire hold_ok = hold_en_r & stopped & pwr_s & ~alarm_s;

always @(posedge clk_i) begin
  if (rst_i) begin
    run_o <= 1'b0;
    cw_o <= `MDA_RST_POL;
    speed_ref_o <= {SW{1'b0}};
    trq_limit_o <= 9'h000;
    decel_mode_o <= `MDA_RST_DECEL;
    hold_o <= 1'b0;
    hold_trq_o <= 8'h00;
    speed_reached_output_o <= 1'b0;
  end else begin
    run_o <= run_nxt & pwr_s & ~alarm_s;
    if (run_nxt)
      cw_o <= ~(plus_nxt ^ pol_r);
    speed_ref_o <= ramp_spd;
    trq_limit_o <= trq_cmd_r;
    decel_mode_o <= decel_r;
    speed_reached_output_o <= run_o &&
                              spd_err <= {{(SW-9){1'b0}}, va_width_r};
    if (!hold_ok)
      hold_o <= 1'b0;
    else if (disp_abs >= {1'b0, `MDA_HOLD_ANGLE_DEG})
      hold_o <= 1'b1;
    hold_trq_o <= hold_ok ? hold_lim : 8'h00;
  end
end

////////////////////////////////////////////////////////////////////////
// Bus answer: one wait state, unmapped reads give zero
reg [31:0] rd_nxt;

always @* begin
  rd_nxt = 32'h0000_0000;
  case (wb_adr_i)
    `MDA_REG_MODE: begin
      rd_nxt[`MDA_F_WIRE] = wire_stg_r;
      rd_nxt[`MDA_F_POL] = pol_stg_r;
      rd_nxt[`MDA_F_HOLD] = hold_stg_r;
      rd_nxt[`MDA_F_DECEL] = decel_r;
      rd_nxt[`MDA_F_FILT] = filt_stg_r;
    end
    `MDA_REG_SPD_GAIN: rd_nxt[11:0] = spd_gain_r;
    `MDA_REG_SPD_OFS: rd_nxt[11:0] = spd_ofs_r;
    `MDA_REG_TRQ_GAIN: rd_nxt[7:0] = trq_gain_r;
    `MDA_REG_TRQ_OFS: rd_nxt[7:0] = trq_ofs_r;
    `MDA_REG_SPD_UPPER: rd_nxt[11:0] = spd_upper_r;
    `MDA_REG_VA_WIDTH: rd_nxt[8:0] = va_width_r;
    `MDA_REG_HOLD_TRQ: rd_nxt[7:0] = {hold_trq_r[6], hold_trq_r};
    `MDA_REG_STATUS: rd_nxt[9:0] = {filt_r, hold_o, speed_reached_output_o,
                                   cw_o, run_o, hold_en_r, pol_r, wire_r, stopped};
    `MDA_REG_SPD_CMD: rd_nxt[11:0] = spd_cmd_r;
    `MDA_REG_TRQ_CMD: rd_nxt[8:0] = trq_cmd_r;
    default: rd_nxt = 32'h0000_0000;
  endcase
end

always @(posedge clk_i) begin
  if (rst_i) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h0000_0000;
  end else begin
    wb_ack_o <= acc;
    wb_dat_o <= (acc & ~wb_we_i) ? rd_nxt : 32'h0000_0000;
  end
end

endmodule
`default_nettype wire

//--- verification/mda_top_sva.sv
// Assertions on the ports of mda_top.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
module mda_chk #(
  parameter SW = 12,
  parameter RAMP_STEP = 12'd1
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_ack_o, // Bus acknowledge
  input wire logic power_ok_i, // Power present
  input wire logic alarm_i, // Alarm
  input wire logic signed [8:0] shaft_disp_i, // Shaft angle
  input wire logic run_o, // Running
  input wire logic [SW-1:0] speed_ref_o, // Speed reference
  input wire logic [8:0] trq_limit_o, // Torque limit
  input wire logic hold_o, // Holding force
  input wire logic [7:0] hold_trq_o, // Holding torque
  input wire logic speed_reached_output_o // Speed reached
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_HOLD_CAP: assert property (hold_trq_o <= 8'h32)
    else $error("holding torque above half rated");
  AST_TRQ_CAP: assert property (trq_limit_o <= 9'h0c8)
    else $error("torque limit above ceiling");
  // Pins pass two sync flops, so allow a few cycles before the force must go
  AST_HOLD_LOSS: assert property ((!power_ok_i || alarm_i) [*6] |-> !hold_o && hold_trq_o == 8'h00)
    else $error("holding kept without power or with alarm");
  AST_HOLD_IDLE: assert property (hold_o |-> !$past(run_o))
    else $error("holding while running");
  AST_HOLD_ANGLE: assert property ($rose(hold_o) |-> $past(shaft_disp_i) >= 15 ||
    $past(shaft_disp_i) <= -15)
    else $error("holding began below the angle");
  AST_REACH_RUN: assert property (speed_reached_output_o |-> $past(run_o))
    else $error("speed reached while stopped");
  AST_RAMP_RATE: assert property ((speed_ref_o >= $past(speed_ref_o) ?
    speed_ref_o - $past(speed_ref_o) : $past(speed_ref_o) - speed_ref_o) <= RAMP_STEP)
    else $error("speed reference jumped");
  cover property (hold_o);
  cover property (speed_reached_output_o);
  cover property (run_o && speed_ref_o != 0);
endmodule
bind mda_top mda_chk #(.SW(SW), .RAMP_STEP(RAMP_STEP)) i_mda_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .power_ok_i, .alarm_i, .shaft_disp_i, .run_o, .speed_ref_o,
  .trq_limit_o, .hold_o, .hold_trq_o, .speed_reached_output_o);
`default_nettype wire

//--- verification/mda_motor_model.sv
// Motor feedback model: reports shaft speed around the commanded reference.
// Assumes the bench sets the speed error the drive should see.
`default_nettype none
module mda_motor_model (
  input wire logic run_i, // Drive running
  input wire logic [11:0] speed_ref_i, // Commanded speed
  input wire logic [11:0] slip_i, // Speed error, two's complement
  output logic [11:0] actual_speed_o // Measured speed
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // A stopped motor reports zero so no stale speed lingers
  assign actual_speed_o = run_i ? speed_ref_i + slip_i : 12'h000;
endmodule
`default_nettype wire

//--- verification/test_mda_top.sv
// Self-checking bench for mda_top with a motor model on its far side.
// Assumes mda_defs.vh on the include path and one 250 MHz clock.
`default_nettype none
`include "mda_defs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module test_mda_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, run_o, cw_o, hold_o;
  logic forward_run_input_i, reverse_run_i, start_run_i, run_direction_input_i;
  logic power_ok_i, alarm_i, speed_reached_output_o;
  logic [7:0] wb_adr_i, opdata_trq_i, hold_trq_o;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [13:0] spd_mv_i, trq_mv_i;
  logic [11:0] act, speed_ref_o, slip;
  logic signed [8:0] shaft_disp_i;
  logic [8:0] trq_limit_o;
  logic [1:0] decel_mode_o;
  int error_cnt, compares, g, o, mv, e;
  ////////////////////////////////////////
  mda_top #(.RAMP_STEP(12'h064)) i_mda_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .forward_run_input_i, .reverse_run_i,
    .start_run_i, .run_direction_input_i, .power_ok_i, .alarm_i, .spd_mv_i, .trq_mv_i,
    .actual_speed_i(act), .shaft_disp_i, .opdata_trq_i, .run_o, .cw_o, .speed_ref_o,
    .trq_limit_o, .decel_mode_o, .hold_o, .hold_trq_o, .speed_reached_output_o);
  mda_motor_model i_mda_motor_model (.run_i(run_o), .speed_ref_i(speed_ref_o), .slip_i(slip),
    .actual_speed_o(act));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  function automatic int clampi(int v, int hi);
    return v < 0 ? 0 : (v > hi ? hi : v);
  endfunction
  // Ack is read at the edge it is sampled, before that edge's updates land
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    // Only the watchdog ends a wait for the answer
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(a, 1'b0, 32'h0000_0000);
    `CHK(q, x)
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_i);
    error_cnt++;
    test_done();
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, forward_run_input_i, reverse_run_i, alarm_i} = '0;
    {start_run_i, run_direction_input_i, wb_adr_i, wb_dat_i, spd_mv_i, trq_mv_i, slip} = '0;
    shaft_disp_i = '0;
    wb_sel_i = 4'hf;
    power_ok_i = 1'b1;
    opdata_trq_i = 8'h50;
    error_cnt = 0;
    compares = 0;
    rst_i = 1'b1;
    void'($urandom(32'h6eae));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(cw_o, 1'b1)
    rd(`MDA_REG_MODE, 32'h0000_0003);
    rd(`MDA_REG_STATUS, 32'h0000_0027);
    rd(`MDA_REG_HOLD_TRQ, 32'h0000_00ff);
    rd(`MDA_REG_VA_WIDTH, 32'h0000_00c8);
    rd(`MDA_REG_SPD_GAIN, 32'h0000_0280);
    rd(`MDA_REG_TRQ_GAIN, 32'h0000_002b);
    wb(8'h30, 1'b1, 32'hffff_ffff);
    rd(8'h30, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      wb(`MDA_REG_MODE, 1'b1, 32'h0000_0003 | (m << 4));
      `CHK(decel_mode_o, 2'(m < 3 ? m : 2))
    end
    for (int i = 0; i < 8; i++) begin
      g = i == 0 ? 3150 : $urandom_range(3150, 0);
      o = $urandom_range(3000, 0) - 1500;
      mv = $urandom_range(10000, 0);
      e = i < 4 ? 3150 : 1500;
      spd_mv_i <= 14'(mv);
      wb(`MDA_REG_SPD_GAIN, 1'b1, g);
      wb(`MDA_REG_SPD_OFS, 1'b1, o);
      wb(`MDA_REG_SPD_UPPER, 1'b1, e);
      rd(`MDA_REG_SPD_CMD, 32'(clampi(g * mv / 1000 + o, e)));
    end
    wb(`MDA_REG_SPD_GAIN, 1'b1, 3151);
    rd(`MDA_REG_SPD_GAIN, g);
    for (int i = 0; i < 6; i++) begin
      g = i == 0 ? 200 : $urandom_range(200, 0);
      o = $urandom_range(200, 0) - 100;
      mv = $urandom_range(10000, 0);
      trq_mv_i <= 14'(mv);
      wb(`MDA_REG_TRQ_GAIN, 1'b1, g);
      wb(`MDA_REG_TRQ_OFS, 1'b1, o);
      repeat (2) @(posedge clk_i);
      `CHK(trq_limit_o, 9'(clampi(g * mv / 1000 + o, 200)))
    end
    wb(`MDA_REG_TRQ_GAIN, 1'b1, 201);
    rd(`MDA_REG_TRQ_GAIN, g);
    wb(`MDA_REG_SPD_UPPER, 1'b1, 3150);
    wb(`MDA_REG_SPD_OFS, 1'b1, 0);
    wb(`MDA_REG_SPD_GAIN, 1'b1, 640);
    spd_mv_i <= 14'h07d0;
    start_run_i <= 1'b1;
    run_direction_input_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK({run_o, cw_o}, 2'h3)
    run_direction_input_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    `CHK(cw_o, 1'b0)
    wb(`MDA_REG_VA_WIDTH, 1'b1, 10);
    repeat (2000) @(posedge clk_i);
    `CHK(speed_reached_output_o, 1'b0)
    repeat (14000) @(posedge clk_i);
    `CHK(speed_ref_o, 12'd1280)
    for (int i = 0; i < 4; i++) begin
      slip <= 12'(i < 2 ? 9 + i : -8 - i);
      repeat (4) @(posedge clk_i);
      `CHK(speed_reached_output_o, i != 3)
    end
    wb(`MDA_REG_VA_WIDTH, 1'b1, 0);
    wb(`MDA_REG_VA_WIDTH, 1'b1, 401);
    rd(`MDA_REG_VA_WIDTH, 32'h0000_000a);
    // Polarity stays pending until the configuration command, filter while the motor runs
    wb(`MDA_REG_MODE, 1'b1, 32'h0000_0121);
    rd(`MDA_REG_STATUS, 32'h0000_0016);
    wb(`MDA_REG_CFG_CMD, 1'b1, 1);
    repeat (6) @(posedge clk_i);
    `CHK(cw_o, 1'b1)
    wb(`MDA_REG_MODE, 1'b1, 32'h0000_0120);
    wb(`MDA_REG_CFG_CMD, 1'b1, 1);
    start_run_i <= 1'b0;
    forward_run_input_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK({run_o, cw_o}, 2'h2)
    forward_run_input_i <= 1'b0;
    reverse_run_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK({run_o, cw_o}, 2'h3)
    forward_run_input_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK(run_o, 1'b0)
    while (run_o !== 1'b0 || speed_ref_o !== 12'h000) begin
      @(posedge clk_i);
    end
    wb(`MDA_REG_MODE, 1'b1, 32'h0000_0324);
    wb(`MDA_REG_CFG_CMD, 1'b1, 1);
    shaft_disp_i <= -9'sd14;
    repeat (6) @(posedge clk_i);
    wb(`MDA_REG_STATUS, 1'b0, 32'h0000_0000);
    `CHK(q & 32'h0000_030b, 32'h0000_0109)
    `CHK({hold_o, hold_trq_o}, {1'b0, 8'h32})
    opdata_trq_i <= 8'h1e;
    shaft_disp_i <= -9'sd15;
    repeat (6) @(posedge clk_i);
    `CHK({hold_o, hold_trq_o}, {1'b1, 8'h1e})
    wb(`MDA_REG_HOLD_TRQ, 1'b1, 20);
    wb(`MDA_REG_HOLD_TRQ, 1'b1, 51);
    `CHK(hold_trq_o, 8'h14)
    power_ok_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK({hold_o, hold_trq_o}, 9'h000)
    power_ok_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK(hold_o, 1'b1)
    alarm_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK({hold_o, hold_trq_o}, 9'h000)
    // Filter one is now in use: the ramp must lag well behind the plain ramp
    alarm_i <= 1'b0;
    reverse_run_i <= 1'b0;
    repeat (5000) @(posedge clk_i);
    `CHK(hold_o, 1'b0)
    `CHK(speed_ref_o > 12'h000 && speed_ref_o < 12'h0c8, 1'b1)
    test_done();
  end
endmodule
`default_nettype wire
